// [cmd_picker.sv]
// Lowest-set-bit picker for pending command bits
`timescale 1ns/100ps
module cmd_picker #(
  parameter int W = 7
)
(
  input wire logic [W-1:0] pending, // Bits still to act on
  output logic [W-1:0] lowest, // One-hot lowest pending bit
  output logic [W-1:0] rest // Pending bits without it
);
  function automatic logic [W-1:0] lowest_set(input logic [W-1:0] v);
    return v & (~v + 1'b1);
  endfunction

  assign lowest = lowest_set(pending);
  assign rest = pending & ~lowest;
endmodule

// [ms_timer.sv]
// Millisecond timeout counter for the wait command
`timescale 1ns/100ps
module ms_timer #(
  parameter int CYCLES_PER_MS = 40000
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Count while high
  input wire logic [31:0] limit_ms, // Limit, zero means never
  output logic expired // High once limit reached
);
  localparam int PW = $clog2(CYCLES_PER_MS);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

  logic [PW-1:0] pre;
  logic [31:0] ms;
  wire tick = pre == PRE_LAST;

  generate
    if (CYCLES_PER_MS < 2)
    begin : bad_cfg
      $error("CYCLES_PER_MS must be at least 2");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= '0;
      ms <= '0;
      expired <= 1'b0;
    end
    else if (!run)
    begin
      pre <= '0;
      ms <= '0;
      expired <= 1'b0;
    end
    else
    begin
      pre <= tick ? '0 : pre + 1'b1;
      ms <= tick ? ms + 32'h1 : ms;
      expired <= (limit_ms != 32'h0) && (ms >= limit_ms);
    end
  end
endmodule

// [sync_hub_card_model.sv]
// Behavioural model of the synchronized cards behind the hub
`timescale 1ns/100ps
module sync_hub_card_model
  import sync_hub_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire card_cmd_t card_cmd, // Command from hub
  input wire logic hold, // Keep the run going
  input wire logic fire, // Request one trigger event
  output logic hub_card_ready, // Hub card finished
  output logic trig_in // Trigger event to hub
);
  logic busy;

  // ----------------------------------------
  // Run state of the hub card
  // ----------------------------------------
  // Ready drops in the very cycle the start reaches the card
  assign hub_card_ready = !busy && !card_cmd.begin_run;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      trig_in <= 1'b0;
    end
    else
    begin
      trig_in <= fire;
      if (card_cmd.begin_run)
        busy <= 1'b1;
      else if (card_cmd.end_run || card_cmd.full_reset || !hold)
        busy <= 1'b0;
    end
  end
endmodule

// [sync_hub_command_dispatch.sv]
// APB command dispatcher of the card synchronization hub
`timescale 1ns/100ps
module sync_hub_command_dispatch
  import sync_hub_pkg::*;
#(
  parameter int NUM_CARDS = NUM_CARDS_DEF,
  parameter int HUB_POS = 0,
  parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic hub_card_ready, // Hub card reached ready
  input wire logic trig_in, // Detected trigger event
  output card_cmd_t card_cmd, // Command to cards
  output logic [NUM_CARDS-1:0] card_strobe, // Cards that take it
  output logic sys_trigger, // Trigger to all cards
  output logic [31:0] eff_trig_delay // Delay used by cards
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (NUM_CARDS < 1 || NUM_CARDS > 32 || HUB_POS < 0 || HUB_POS >= NUM_CARDS)
    begin : bad_cfg
      $error("NUM_CARDS or HUB_POS out of range");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  hub_state_t st;
  hub_state_t next_st;
  logic [NUM_CARDS-1:0] pmask;
  logic [NUM_CARDS-1:0] cmask;
  logic [NUM_CARDS-1:0] fwd_mask;
  logic [31:0] timeout_ms;
  logic [31:0] trig_delay;
  logic [CMD_W-1:0] pending;
  logic wait_req;
  logic running;
  logic armed;
  logic dirty;
  logic setup_err;
  logic timeout_err;
  logic hub_ready_q;
  logic [CMD_W-1:0] lowest;
  logic [CMD_W-1:0] rest;
  logic expired;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire access = psel & penable & ~pready;
  wire take = access & (st == ST_IDLE);
  wire hit_cmd = paddr == OFF_RUN_COMMAND;
  wire hit_part = paddr == OFF_PARTICIPANT;
  wire hit_clk = paddr == OFF_CLOCK_MASTER;
  wire hit_tmo = paddr == OFF_TIMEOUT;
  wire hit_dly = paddr == OFF_TRIG_DELAY;
  wire hit_stat = paddr == OFF_STATUS;
  wire mapped = hit_cmd | hit_part | hit_clk | hit_tmo | hit_dly | hit_stat;

  // ----------------------------------------
  // Command checks
  // ----------------------------------------
  wire [CMD_W-1:0] new_bits = pwdata[CMD_W-1:0];
  wire needs_check = new_bits[BIT_APPLY_CONFIG] | new_bits[BIT_BEGIN_RUN];
  // One clock master, inside the participants, hub card included
  wire setup_ok = $onehot(cmask) && ((cmask & ~pmask) == '0) && pmask[HUB_POS];
  wire frozen_hit = running & (hit_part | hit_clk | hit_dly);
  wire cmd_fail = pwrite & hit_cmd & needs_check & ~setup_ok;
  wire bad = ~mapped | (pwrite & frozen_hit) | cmd_fail;
  wire wr_ok = take & pwrite & ~bad;
  wire go_cmd = wr_ok & hit_cmd;
  // Start pulls in a setup write if settings changed
  wire [CMD_W-1:0] apply_add = {{(CMD_W-1){1'b0}}, new_bits[BIT_BEGIN_RUN] & dirty} << BIT_APPLY_CONFIG;
  wire [CMD_W-1:0] load_bits = new_bits | apply_add;

  // ----------------------------------------
  // Ordered dispatch
  // ----------------------------------------
  cmd_picker #(
    .W(CMD_W)
  ) u_picker (
    .pending(pending),
    .lowest(lowest),
    .rest(rest)
  );

  wire in_disp = st == ST_DISPATCH;
  wire [CMD_W-1:0] pick = in_disp ? lowest : '0;
  wire p_reset = pick[BIT_FULL_RESET];
  wire p_apply = pick[BIT_APPLY_CONFIG];
  wire p_begin = pick[BIT_BEGIN_RUN];
  wire p_arm = pick[BIT_ARM_TRIGGER];
  wire p_force = pick[BIT_FORCE_TRIGGER];
  wire p_disarm = pick[BIT_DISARM_TRIGGER];
  wire p_end = pick[BIT_END_RUN];
  // Stop is dropped when nothing runs
  wire end_fwd = p_end & running;
  wire [CMD_W-1:0] fwd_bits = {end_fwd, pick[CMD_W-2:0]};
  wire hub_rise = hub_card_ready & ~hub_ready_q;

  // ----------------------------------------
  // Wait and completion
  // ----------------------------------------
  ms_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(st == ST_WAIT),
    .limit_ms(timeout_ms),
    .expired(expired)
  );

  wire in_wait = st == ST_WAIT;
  wire wait_end = hub_card_ready | expired;
  wire wait_fail = in_wait & expired & ~hub_card_ready;
  wire disp_done = in_disp & (pending == '0);
  wire next_ready = (take & ~go_cmd) | (disp_done & ~wait_req) | (in_wait & wait_end);

  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:
        if (go_cmd)
          next_st = ST_DISPATCH;
      ST_DISPATCH:
        if (pending == '0)
          next_st = wait_req ? ST_WAIT : ST_IDLE;
      ST_WAIT:
        if (wait_end)
          next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire hub_status_t stat_now = {~(st == ST_IDLE), timeout_err, setup_err, dirty, armed, running};
  wire [31:0] rd_val = hit_part ? 32'(pmask) :
                       hit_clk ? 32'(cmask) :
                       hit_tmo ? timeout_ms :
                       hit_dly ? trig_delay :
                       hit_stat ? 32'(stat_now) :
                       READ_ZERO;

  // ----------------------------------------
  // APB answer and sequencing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= READ_ZERO;
    end
    else
    begin
      st <= next_st;
      pready <= next_ready;
      pslverr <= (take & bad) | wait_fail;
      prdata <= (take & ~pwrite) ? rd_val : READ_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending <= '0;
      wait_req <= 1'b0;
      fwd_mask <= '0;
    end
    else if (go_cmd)
    begin
      pending <= load_bits;
      wait_req <= pwdata[BIT_WAIT_READY];
      fwd_mask <= pmask;
    end
    else if (in_disp)
      pending <= rest;
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmask <= '0;
      cmask <= '0;
      timeout_ms <= TIMEOUT_RST_MS;
      trig_delay <= DELAY_RST;
    end
    else if (p_reset)
    begin
      pmask <= '0;
      cmask <= '0;
      timeout_ms <= TIMEOUT_RST_MS;
      trig_delay <= DELAY_RST;
    end
    else if (wr_ok)
    begin
      if (hit_part)
        pmask <= pwdata[NUM_CARDS-1:0];
      if (hit_clk)
        cmask <= pwdata[NUM_CARDS-1:0];
      if (hit_tmo)
        timeout_ms <= pwdata;
      if (hit_dly)
        trig_delay <= pwdata;
    end
  end

  // ----------------------------------------
  // Run and trigger state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      running <= 1'b0;
      armed <= 1'b0;
      dirty <= 1'b0;
      hub_ready_q <= 1'b1;
    end
    else
    begin
      hub_ready_q <= hub_card_ready;
      if (p_reset | p_end)
        running <= 1'b0;
      else if (p_begin)
        running <= 1'b1;
      else if (hub_rise)
        running <= 1'b0;
      if (p_reset | p_begin | p_disarm)
        armed <= 1'b0;
      else if (p_arm)
        armed <= 1'b1;
      if (p_reset | p_apply | p_begin)
        dirty <= 1'b0;
      else if (wr_ok & (hit_part | hit_clk | hit_dly))
        dirty <= 1'b1;
    end
  end

  // ----------------------------------------
  // Error flags, write one to clear
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setup_err <= 1'b0;
      timeout_err <= 1'b0;
    end
    else
    begin
      if (take & cmd_fail)
        setup_err <= 1'b1;
      else if (p_reset | (wr_ok & hit_stat & pwdata[STAT_SETUP_ERR]))
        setup_err <= 1'b0;
      if (wait_fail)
        timeout_err <= 1'b1;
      else if (p_reset | (wr_ok & hit_stat & pwdata[STAT_TIMEOUT_ERR]))
        timeout_err <= 1'b0;
    end
  end

  // ----------------------------------------
  // Card-side outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_cmd <= '0;
      card_strobe <= '0;
      sys_trigger <= 1'b0;
      eff_trig_delay <= DELAY_RST;
    end
    else
    begin
      card_cmd <= card_cmd_t'(fwd_bits);
      card_strobe <= (fwd_bits != '0) ? fwd_mask : '0;
      sys_trigger <= p_force | (armed & running & trig_in);
      eff_trig_delay <= (pmask != '0) ? DELAY_RST : trig_delay;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  one_cmd_a: assert property ($onehot0(card_cmd))
    else $error("more than one command bit sent at once");
  order_up_a: assert property (in_disp && pending != '0 |=> (pending & ~$past(pending)) == '0
    && (pending & $past(lowest)) == '0)
    else $error("pending bits not consumed lowest first");
  start_disarm_a: assert property (p_begin |=> !armed && running)
    else $error("start did not leave trigger disarmed");
  arm_set_a: assert property (p_arm |=> armed)
    else $error("arm command did not arm");
  disarm_set_a: assert property (p_disarm ##1 !p_arm [*2] |-> !armed && !sys_trigger)
    else $error("trigger passed while disarmed");
  force_trig_a: assert property (p_force |=> sys_trigger)
    else $error("forced trigger missing");
  stop_idle_a: assert property (p_end && !running |=> card_cmd == '0 && card_strobe == '0)
    else $error("stop forwarded while not running");
  full_reset_a: assert property (p_reset |=> !running && !armed && pmask == '0)
    else $error("full reset left state behind");
  apply_cfg_a: assert property (p_apply |=> !dirty && card_cmd.apply_config)
    else $error("setup write not applied");
  start_apply_a: assert property (go_cmd && new_bits[BIT_BEGIN_RUN] && dirty |=> pending[BIT_APPLY_CONFIG])
    else $error("start did not apply changed settings");
  frozen_set_a: assert property (take && pwrite && hit_part && running |=> pready && pslverr
    && $stable(pmask))
    else $error("settings changed while running");
  delay_off_a: assert property (pmask != '0 |=> eff_trig_delay == DELAY_RST)
    else $error("trigger delay used while synchronized");
  cmd_wo_a: assert property (take && !pwrite && hit_cmd |=> pready && prdata == READ_ZERO)
    else $error("command register read returned data");
  mask_rw_a: assert property (wr_ok && hit_part |=> pmask == $past(pwdata[NUM_CARDS-1:0]))
    else $error("participant mask write lost");
  wait_done_a: assert property (in_wait && hub_card_ready |=> pready && !pslverr)
    else $error("wait did not end on hub card ready");
  wait_tmo_a: assert property (wait_fail |=> pready && pslverr && timeout_err)
    else $error("wait timeout not reported");
endmodule

// [sync_hub_pkg.sv]
// Constants, types and register map of the synchronization hub command dispatcher
//
// What this block does
// - Trigger delay ignored while cards synchronized
// - Hub validates setup, forwards commands in order
// - Write-only command register at offset 100
// - Bit 1h performs full card reset
// - Bit 2h applies configuration without running
// - Bit 4h starts, applies changes, freezes settings except timeout
// - Bit 8h arms trigger, with start or later
// - Bit 10h forces a trigger event
// - Bit 20h disarms, later triggers ignored
// - Every start begins with trigger disarmed
// - Bit 40h stops run, else no effect
// - Wait ends when hub card is ready
// - Wait reports timeout after programmed milliseconds
// - Read/write participant mask at offset 49200
package sync_hub_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_IN_NS = 1000000;
  localparam int unsigned CYCLES_PER_MS_DEF = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] TIMEOUT_RST_MS = 32'h0000_03e8; // 1000 ms
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int NUM_CARDS_DEF = 8;
  localparam logic [ADDR_W-1:0] OFF_RUN_COMMAND = 16'h0064; // 100
  localparam logic [ADDR_W-1:0] OFF_PARTICIPANT = 16'hc030; // 49200
  localparam logic [ADDR_W-1:0] OFF_CLOCK_MASTER = 16'hc044; // 49220
  localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 16'h0200;
  localparam logic [ADDR_W-1:0] OFF_TRIG_DELAY = 16'h0204;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 16'h0208;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // Command bits, status bits
  // ----------------------------------------
  localparam int CMD_W = 7;
  localparam int BIT_FULL_RESET = 0;
  localparam int BIT_APPLY_CONFIG = 1;
  localparam int BIT_BEGIN_RUN = 2;
  localparam int BIT_ARM_TRIGGER = 3;
  localparam int BIT_FORCE_TRIGGER = 4;
  localparam int BIT_DISARM_TRIGGER = 5;
  localparam int BIT_END_RUN = 6;
  localparam int BIT_WAIT_READY = 14;
  localparam int STAT_SETUP_ERR = 3;
  localparam int STAT_TIMEOUT_ERR = 4;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic end_run;
    logic disarm_trigger;
    logic force_trigger;
    logic arm_trigger;
    logic begin_run;
    logic apply_config;
    logic full_reset;
  } card_cmd_t;
  typedef struct packed {
    logic busy;
    logic timeout_err;
    logic setup_err;
    logic dirty;
    logic armed;
    logic running;
  } hub_status_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_DISPATCH = 3'h2,
    ST_WAIT = 3'h4
  } hub_state_t;
endpackage

// [test_sync_hub_command_dispatch.sv]
// Self-checking testbench of the hub command dispatcher
`timescale 1ns/100ps
module test_sync_hub_command_dispatch
  import sync_hub_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hub_card_ready;
  logic trig_in;
  card_cmd_t card_cmd;
  logic [7:0] card_strobe;
  logic sys_trigger;
  logic [31:0] eff_trig_delay;
  logic hold;
  logic fire;
  logic [31:0] rd;
  logic [31:0] dly;
  logic err;
  logic [7:0] mask;
  logic [14:0] exp_q[$];
  int n_errors;
  int tests_run;
  int n_trig;
  integer seed;

  sync_hub_command_dispatch #(.NUM_CARDS(8), .HUB_POS(0), .CYCLES_PER_MS(4)) u_sync_hub_command_dispatch (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hub_card_ready(hub_card_ready),
    .trig_in(trig_in), .card_cmd(card_cmd), .card_strobe(card_strobe), .sys_trigger(sys_trigger),
    .eff_trig_delay(eff_trig_delay));

  sync_hub_card_model u_sync_hub_card_model (
    .pclk(pclk), .presetn(presetn), .card_cmd(card_cmd), .hold(hold), .fire(fire),
    .hub_card_ready(hub_card_ready), .trig_in(trig_in));

  always #12.5 pclk = ~pclk;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 200)
    begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    check({31'h0, err}, {31'h0, e});
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // Expected card pulse: latched participant mask with one command bit
  task automatic ex(input logic [6:0] c);
    exp_q.push_back({mask, c});
  endtask

  task automatic fire_trig();
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge pclk)
  begin
    if (sys_trigger === 1'b1)
      n_trig++;
    if (card_cmd !== '0)
    begin
      if (exp_q.size() == 0)
        check({17'h0, card_strobe, card_cmd}, 32'h0);
      else
        check({17'h0, card_strobe, card_cmd}, {17'h0, exp_q.pop_front()});
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    hold = 1'b1;
    fire = 1'b0;
    mask = 8'h00;
    n_errors = 0;
    tests_run = 0;
    n_trig = 0;
    seed = 32'h34189e34;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check(eff_trig_delay, 32'h0);
    rdchk(OFF_TIMEOUT, 32'h3e8);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_RUN_COMMAND, 32'h0);
    apb(1'b0, 16'h0300, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(OFF_RUN_COMMAND, 32'h0c, 1'b1);
    rdchk(OFF_STATUS, 32'h08);
    wr(OFF_STATUS, 32'h08, 1'b0);
    dly = $random(seed);
    wr(OFF_TRIG_DELAY, dly, 1'b0);
    @(posedge pclk);
    check(eff_trig_delay, dly);
    mask = 8'($random(seed)) | 8'h01;
    wr(OFF_PARTICIPANT, {24'h0, mask}, 1'b0);
    rdchk(OFF_PARTICIPANT, {24'h0, mask});
    wr(OFF_CLOCK_MASTER, 32'h1, 1'b0);
    @(posedge pclk);
    check(eff_trig_delay, 32'h0);
    // Start with arm on a dirty setup
    ex(7'h02);
    ex(7'h04);
    ex(7'h08);
    wr(OFF_RUN_COMMAND, 32'h0c, 1'b0);
    rdchk(OFF_STATUS, 32'h03);
    fire_trig();
    check(n_trig, 32'h1);
    ex(7'h10);
    wr(OFF_RUN_COMMAND, 32'h10, 1'b0);
    ex(7'h20);
    wr(OFF_RUN_COMMAND, 32'h20, 1'b0);
    fire_trig();
    check(n_trig, 32'h2);
    wr(OFF_PARTICIPANT, 32'hff, 1'b1);
    ex(7'h40);
    wr(OFF_RUN_COMMAND, 32'h40, 1'b0);
    wr(OFF_RUN_COMMAND, 32'h40, 1'b0);
    // Plain start comes up disarmed
    ex(7'h04);
    wr(OFF_RUN_COMMAND, 32'h04, 1'b0);
    fire_trig();
    check(n_trig, 32'h2);
    hold <= 1'b0;
    wr(OFF_RUN_COMMAND, 32'h4000, 1'b0);
    rdchk(OFF_STATUS, 32'h0);
    ex(7'h01);
    wr(OFF_RUN_COMMAND, 32'h01, 1'b0);
    rdchk(OFF_PARTICIPANT, 32'h0);
    // Apply alone, then a wait that runs out
    wr(OFF_PARTICIPANT, {24'h0, mask}, 1'b0);
    wr(OFF_CLOCK_MASTER, 32'h1, 1'b0);
    wr(OFF_TIMEOUT, 32'h2, 1'b0);
    ex(7'h02);
    wr(OFF_RUN_COMMAND, 32'h02, 1'b0);
    rdchk(OFF_STATUS, 32'h0);
    hold <= 1'b1;
    ex(7'h04);
    wr(OFF_RUN_COMMAND, 32'h4004, 1'b1);
    rdchk(OFF_STATUS, 32'h11);
    wr(OFF_STATUS, 32'h10, 1'b0);
    rdchk(OFF_STATUS, 32'h01);
    // Two clock masters refuse the next start
    ex(7'h40);
    wr(OFF_RUN_COMMAND, 32'h40, 1'b0);
    wr(OFF_CLOCK_MASTER, 32'h3, 1'b0);
    wr(OFF_RUN_COMMAND, 32'h04, 1'b1);
    rdchk(OFF_STATUS, 32'h0c);
    check(exp_q.size(), 32'h0);
    final_report();
  end
endmodule
